// ### inc/pabm_defs.svh
// Overview of operation
// - global pullup disable kills every pullup
// - port a overrides zero, analog passthrough
// - spi slave forces clock pin input
// - spi master: clock direction follows bit
// - master forces miso input; slave follows bit
// - spi slave forces mosi input
// - spi master: mosi direction follows bit
// - spi slave forces select pin input
// - slave spi active only while select low
// - spi master: select direction follows bit
// - forced inputs keep pullup from output bit
// - bit 3 carries timer compare output
// - bit 2 feeds external interrupt source 2
// - pullup from override, else dir/out/disable 010
// - driver from direction override, else direction bit
// - value from override when enabled, else output bit
`ifndef PABM_DEFS_SVH
`define PABM_DEFS_SVH
// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define PABM_ADDR_SFC 12'h000
`define PABM_ADDR_PA_DIR 12'h004
`define PABM_ADDR_PA_OUT 12'h008
`define PABM_ADDR_PB_DIR 12'h00C
`define PABM_ADDR_PB_OUT 12'h010
`define PABM_ADDR_SPI_CTL 12'h014
`define PABM_ADDR_IRQ_STAT 12'h018
`define PABM_ADDR_IRQ_MASK 12'h01C
`define PABM_ADDR_PA_PIN 12'h020
`define PABM_ADDR_PB_PIN 12'h024
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define PABM_SFC_RESET 8'h00
`define PABM_SFC_WMASK 8'hEF
`define PABM_PUD_BIT 2
`define PABM_SPI_EN_BIT 0
`define PABM_SPI_MSTR_BIT 1
`define PABM_PIN_SCK 7
`define PABM_PIN_MISO 6
`define PABM_PIN_MOSI 5
`define PABM_PIN_SEL 4
`define PABM_PIN_OC 3
`define PABM_PIN_IRQ2 2
`define PABM_IRQ_SEL_FALL 0
`define PABM_IRQ_SRC2 1
`define PABM_IRQ_BITS 2
`endif

// ### inc/pabm_pkg.sv
package pabm_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic sel;
      logic enable;
      logic write;
      logic [31:0] wdata;
   } pabm_apb_req_t;
   typedef struct packed {
      logic [7:0] oe;
      logic [7:0] o;
      logic [7:0] pu;
   } pabm_pad_t;
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic oc0_en;
      logic oc0;
   } pabm_periph_t;
endpackage

// ### verilog/pabm_pin_ctl.sv
`timescale 1ns/1ns
`include "pabm_defs.svh"
// one pin of the generic override network
module pabm_pin_ctl (
   input wire logic dir_in,
   input wire logic out_in,
   input wire logic pud_in,
   input wire logic pullup_override_enable_in,
   input wire logic pullup_override_value_in,
   input wire logic direction_override_enable_in,
   input wire logic direction_override_value_in,
   input wire logic value_override_enable_in,
   input wire logic value_override_value_in,
   output logic oe_out,
   output logic o_out,
   output logic pu_out
);
   always_comb begin
      oe_out = direction_override_enable_in ? direction_override_value_in : dir_in;
      o_out = value_override_enable_in ? value_override_value_in : out_in;
      // pullup only for input, output bit set, disable clear
      pu_out = pullup_override_enable_in ? pullup_override_value_in
                       : ({dir_in, out_in, pud_in} == 3'b010);
   end
endmodule

// ### verilog/pabm_top.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "pabm_defs.svh"
module pabm_top (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [11:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   input wire logic [7:0] pa_pin_in,
   input wire logic [7:0] pb_pin_in,
   input wire pabm_pkg::pabm_periph_t periph_in,
   output pabm_pkg::pabm_pad_t pa_pad_out,
   output pabm_pkg::pabm_pad_t pb_pad_out,
   output logic [7:0] analog_chan_en_out,
   output logic spi_sel_active_out,
   output logic spi_sck_out,
   output logic spi_mosi_out,
   output logic spi_miso_out,
   output logic external_irq_source_2_out,
   output logic comparator_positive_input_out,
   output logic comparator_negative_input_out
);
   import pabm_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] sfc_q;
   logic [7:0] pa_dir_q;
   logic [7:0] pa_out_q;
   logic [7:0] pb_dir_q;
   logic [7:0] pb_out_q;
   logic [1:0] spi_ctl_q;
   logic [`PABM_IRQ_BITS-1:0] irq_stat_q;
   logic [`PABM_IRQ_BITS-1:0] irq_mask_q;
   logic irq2_prev_q;
   logic irq2_arm_q;
   logic sel_prev_q;
   pabm_apb_req_t req;
   logic wr_acc;
   logic rd_acc;
   logic hit;
   logic [31:0] rdata_d;

   function automatic logic is_addr(input logic [11:0] a,
                                    input logic [11:0] b);
      is_addr = (a == b);
   endfunction

   assign req = '{addr: paddr_in, sel: psel_in, enable: penable_in,
                  write: pwrite_in, wdata: pwdata_in};
   // two-cycle access phase: pready is high only in the second access cycle
   assign wr_acc = req.sel && req.enable && req.write;
   assign rd_acc = req.sel && req.enable && !req.write;

   always_comb begin
      hit = 1'b1;
      rdata_d = 32'h0000_0000;
      case (1'b1)
         is_addr(req.addr, `PABM_ADDR_SFC): rdata_d[7:0] = sfc_q;
         is_addr(req.addr, `PABM_ADDR_PA_DIR): rdata_d[7:0] = pa_dir_q;
         is_addr(req.addr, `PABM_ADDR_PA_OUT): rdata_d[7:0] = pa_out_q;
         is_addr(req.addr, `PABM_ADDR_PB_DIR): rdata_d[7:0] = pb_dir_q;
         is_addr(req.addr, `PABM_ADDR_PB_OUT): rdata_d[7:0] = pb_out_q;
         is_addr(req.addr, `PABM_ADDR_SPI_CTL): rdata_d[1:0] = spi_ctl_q;
         is_addr(req.addr, `PABM_ADDR_IRQ_STAT): begin
            rdata_d[`PABM_IRQ_BITS-1:0] = irq_stat_q;
         end
         is_addr(req.addr, `PABM_ADDR_IRQ_MASK): begin
            rdata_d[`PABM_IRQ_BITS-1:0] = irq_mask_q;
         end
         is_addr(req.addr, `PABM_ADDR_PA_PIN): rdata_d[7:0] = pa_pin_in;
         is_addr(req.addr, `PABM_ADDR_PB_PIN): rdata_d[7:0] = pb_pin_in;
         default: hit = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // bus response
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         // registered ready: access phase lasts two cycles
         pready_out <= req.sel && req.enable && !pready_out;
         pslverr_out <= req.sel && req.enable && !pready_out && !hit;
         prdata_out <= (rd_acc && !pready_out) ? rdata_d : 32'h0000_0000;
      end
   end

   logic wr_en;
   assign wr_en = wr_acc && pready_out;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sfc_q <= `PABM_SFC_RESET;
         pa_dir_q <= 8'h00;
         pa_out_q <= 8'h00;
         pb_dir_q <= 8'h00;
         pb_out_q <= 8'h00;
         spi_ctl_q <= 2'h0;
         irq_mask_q <= '0;
      end else if (wr_en) begin
         // unused sfc bit 4 stays read-only zero
         if (is_addr(req.addr, `PABM_ADDR_SFC)) begin
            sfc_q <= req.wdata[7:0] & `PABM_SFC_WMASK;
         end
         if (is_addr(req.addr, `PABM_ADDR_PA_DIR)) begin
            pa_dir_q <= req.wdata[7:0];
         end
         if (is_addr(req.addr, `PABM_ADDR_PA_OUT)) begin
            pa_out_q <= req.wdata[7:0];
         end
         if (is_addr(req.addr, `PABM_ADDR_PB_DIR)) begin
            pb_dir_q <= req.wdata[7:0];
         end
         if (is_addr(req.addr, `PABM_ADDR_PB_OUT)) begin
            pb_out_q <= req.wdata[7:0];
         end
         if (is_addr(req.addr, `PABM_ADDR_SPI_CTL)) begin
            spi_ctl_q <= req.wdata[1:0];
         end
         if (is_addr(req.addr, `PABM_ADDR_IRQ_MASK)) begin
            irq_mask_q <= req.wdata[`PABM_IRQ_BITS-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // spi override terms
   // ---------------------------------------------------------------
   logic global_pullup_disable;
   logic spi_en;
   logic spi_mstr;
   logic spi_slave;
   assign global_pullup_disable = sfc_q[`PABM_PUD_BIT];
   assign spi_en = spi_ctl_q[`PABM_SPI_EN_BIT];
   assign spi_mstr = spi_ctl_q[`PABM_SPI_MSTR_BIT];
   assign spi_slave = spi_en && !spi_mstr;

   logic [7:0] b_pullup_override_enable;
   logic [7:0] b_pullup_override_value;
   logic [7:0] b_direction_override_enable;
   logic [7:0] b_direction_override_value;
   logic [7:0] b_value_override_enable;
   logic [7:0] b_value_override_value;
   logic slave_out_ok;

   // slave miso value passes only while selected, else forced low
   assign slave_out_ok = spi_slave && !pb_pin_in[`PABM_PIN_SEL];

   always_comb begin
      b_pullup_override_enable = 8'h00;
      b_pullup_override_value = 8'h00;
      b_direction_override_enable = 8'h00;
      b_direction_override_value = 8'h00;
      b_value_override_enable = 8'h00;
      b_value_override_value = 8'h00;
      // slave: clock, mosi, select forced in; master: miso forced in
      b_direction_override_enable[`PABM_PIN_SCK] = spi_slave;
      b_direction_override_enable[`PABM_PIN_MOSI] = spi_slave;
      b_direction_override_enable[`PABM_PIN_SEL] = spi_slave;
      b_direction_override_enable[`PABM_PIN_MISO] = spi_en && spi_mstr;
      // forced inputs: pullup from output bit unless disabled
      b_pullup_override_enable = b_direction_override_enable;
      b_pullup_override_value = pb_out_q & {8{~global_pullup_disable}};
      // master drives clock and mosi, slave drives miso when set
      b_value_override_enable[`PABM_PIN_SCK] = spi_en && spi_mstr;
      b_value_override_value[`PABM_PIN_SCK] = periph_in.sck;
      b_value_override_enable[`PABM_PIN_MOSI] = spi_en && spi_mstr;
      b_value_override_value[`PABM_PIN_MOSI] = periph_in.mosi;
      b_value_override_enable[`PABM_PIN_MISO] = spi_slave;
      b_value_override_value[`PABM_PIN_MISO] = periph_in.miso && slave_out_ok;
      // timer output only reaches pad when direction is output
      b_value_override_enable[`PABM_PIN_OC] = periph_in.oc0_en;
      b_value_override_value[`PABM_PIN_OC] = periph_in.oc0;
   end

   // ---------------------------------------------------------------
   // pin networks
   // ---------------------------------------------------------------
   pabm_pad_t pa_d;
   pabm_pad_t pb_d;

   for (genvar i = 0; i < 8; i++) begin : g_pin
      pabm_pin_ctl u_pa (
         .dir_in(pa_dir_q[i]),
         .out_in(pa_out_q[i]),
         .pud_in(global_pullup_disable),
         .pullup_override_enable_in(1'b0),
         .pullup_override_value_in(1'b0),
         .direction_override_enable_in(1'b0),
         .direction_override_value_in(1'b0),
         .value_override_enable_in(1'b0),
         .value_override_value_in(1'b0),
         .oe_out(pa_d.oe[i]),
         .o_out(pa_d.o[i]),
         .pu_out(pa_d.pu[i])
      );
      pabm_pin_ctl u_pb (
         .dir_in(pb_dir_q[i]),
         .out_in(pb_out_q[i]),
         .pud_in(global_pullup_disable),
         .pullup_override_enable_in(b_pullup_override_enable[i]),
         .pullup_override_value_in(b_pullup_override_value[i]),
         .direction_override_enable_in(b_direction_override_enable[i]),
         .direction_override_value_in(b_direction_override_value[i]),
         .value_override_enable_in(b_value_override_enable[i]),
         .value_override_value_in(b_value_override_value[i]),
         .oe_out(pb_d.oe[i]),
         .o_out(pb_d.o[i]),
         .pu_out(pb_d.pu[i])
      );
   end

   // ---------------------------------------------------------------
   // pad and peripheral outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pa_pad_out <= '0;
         pb_pad_out <= '0;
         analog_chan_en_out <= 8'h00;
      end else begin
         pa_pad_out <= pa_d;
         pb_pad_out <= pb_d;
         // analog path open on every port a pin, channel i per pin i
         analog_chan_en_out <= 8'hFF;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         spi_sel_active_out <= 1'b0;
         spi_sck_out <= 1'b0;
         spi_mosi_out <= 1'b0;
         spi_miso_out <= 1'b0;
         external_irq_source_2_out <= 1'b0;
         comparator_positive_input_out <= 1'b0;
         comparator_negative_input_out <= 1'b0;
      end else begin
         spi_sel_active_out <= slave_out_ok;
         spi_sck_out <= pb_pin_in[`PABM_PIN_SCK];
         spi_mosi_out <= pb_pin_in[`PABM_PIN_MOSI];
         spi_miso_out <= pb_pin_in[`PABM_PIN_MISO];
         external_irq_source_2_out <= pb_pin_in[`PABM_PIN_IRQ2];
         comparator_positive_input_out <= pb_pin_in[`PABM_PIN_IRQ2];
         comparator_negative_input_out <= pb_pin_in[`PABM_PIN_OC];
      end
   end

   // ---------------------------------------------------------------
   // interrupt status: falling select, edge on source 2 pin
   // ---------------------------------------------------------------
   logic [`PABM_IRQ_BITS-1:0] ev;
   logic stat_rd;
   assign ev[`PABM_IRQ_SEL_FALL] = spi_slave && sel_prev_q
                                   && !pb_pin_in[`PABM_PIN_SEL];
   assign ev[`PABM_IRQ_SRC2] = irq2_arm_q
                               && (irq2_prev_q != pb_pin_in[`PABM_PIN_IRQ2]);
   assign stat_rd = rd_acc && pready_out
                    && is_addr(req.addr, `PABM_ADDR_IRQ_STAT);
   logic [`PABM_IRQ_BITS-1:0] stat_d;
   assign stat_d = (irq_stat_q & ~({`PABM_IRQ_BITS{stat_rd}}
                    & prdata_out[`PABM_IRQ_BITS-1:0])) | ev;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq2_prev_q <= 1'b0;
         irq2_arm_q <= 1'b0;
         sel_prev_q <= 1'b1;
         irq_stat_q <= '0;
         irq_out <= 1'b0;
      end else begin
         irq2_prev_q <= pb_pin_in[`PABM_PIN_IRQ2];
         irq2_arm_q <= 1'b1;
         sel_prev_q <= pb_pin_in[`PABM_PIN_SEL];
         // clear only bits the read returned, so late events stay pending
         irq_stat_q <= stat_d;
         irq_out <= |(stat_d & irq_mask_q);
      end
   end
endmodule

// ### tb/pabm_periph_model.sv
`timescale 1ns/1ns
module pabm_periph_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire pabm_pkg::pabm_pad_t pad_in,
   input wire logic [7:0] ext_val_in,
   input wire logic [7:0] ext_drv_in,
   input wire pabm_pkg::pabm_periph_t want_in,
   output pabm_pkg::pabm_periph_t periph_out,
   output logic [7:0] pin_out
);
   import pabm_pkg::*;
   logic [7:0] last_q;
   // timer and spi sources hold what the bench asks for
   assign periph_out = want_in;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) last_q <= 8'h00;
      else last_q <= pin_out;
   end
   // a floating pad without pullup flips so stale levels never pass
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_in.oe[i]) pin_out[i] = pad_in.o[i];
         else if (ext_drv_in[i]) pin_out[i] = ext_val_in[i];
         else if (pad_in.pu[i]) pin_out[i] = 1'b1;
         else pin_out[i] = ~last_q[i];
      end
   end
endmodule

// ### tb/pabm_top_assertions.sv
`timescale 1ns/1ns
module pabm_top_checker (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [7:0] pb_pin_in,
   input wire pabm_pkg::pabm_pad_t pa_pad_out,
   input wire pabm_pkg::pabm_pad_t pb_pad_out,
   input wire logic [7:0] analog_chan_en_out,
   input wire logic spi_sel_active_out,
   input wire logic spi_sck_out,
   input wire logic spi_mosi_out,
   input wire logic spi_miso_out,
   input wire logic external_irq_source_2_out,
   input wire logic comparator_positive_input_out,
   input wire logic comparator_negative_input_out
);
   import pabm_pkg::*;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence setup_s;
      psel_in && !penable_in ##1 psel_in && penable_in;
   endsequence
   sequence warm_s;
      $past(rst_n_in);
   endsequence
   ans_wait_a: assert property (setup_s |=> pready_out)
      else $error("no answer one cycle into access");
   rdy_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   err_rdy_a: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data outside answer");
   chan_pass_a: assert property (warm_s |-> analog_chan_en_out == 8'hFF)
      else $error("analog channel not connected");
   pa_pull_a: assert property ((pa_pad_out.pu & pa_pad_out.oe) == 8'h00)
      else $error("port a pullup on driven pin");
   pb_pull_a: assert property ((pb_pad_out.pu & pb_pad_out.oe) == 8'h00)
      else $error("port b pullup on driven pin");
   sel_act_a: assert property (spi_sel_active_out |-> !$past(pb_pin_in[4]))
      else $error("slave active with select high");
   irq2_copy_a: assert property (warm_s |->
      external_irq_source_2_out == $past(pb_pin_in[2]))
      else $error("interrupt input not following pin");
   cmp_copy_a: assert property (warm_s |->
      comparator_negative_input_out == $past(pb_pin_in[3]))
      else $error("comparator input not following pin");
   spi_copy_a: assert property (warm_s |->
      {spi_sck_out, spi_mosi_out, spi_miso_out}
      == $past({pb_pin_in[7], pb_pin_in[5], pb_pin_in[6]}))
      else $error("spi input not following pin");
   cmp_pos_a: assert property (warm_s |->
      comparator_positive_input_out == $past(pb_pin_in[2]))
      else $error("positive comparator input not following pin");
endmodule
bind pabm_top pabm_top_checker chk_i (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out),
   .pb_pin_in(pb_pin_in), .pa_pad_out(pa_pad_out), .pb_pad_out(pb_pad_out),
   .analog_chan_en_out(analog_chan_en_out),
   .spi_sel_active_out(spi_sel_active_out),
   .spi_sck_out(spi_sck_out), .spi_mosi_out(spi_mosi_out),
   .spi_miso_out(spi_miso_out),
   .external_irq_source_2_out(external_irq_source_2_out),
   .comparator_positive_input_out(comparator_positive_input_out),
   .comparator_negative_input_out(comparator_negative_input_out));

// ### tb/tb.sv
`timescale 1ns/1ns
`include "pabm_defs.svh"
module tb;
   import pabm_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, pen = 1'b0, pwrite = 1'b0, er_v, pready, pslverr;
   logic irq, sel_act;
   logic [31:0] pwdata = 32'h0, rd_v, prdata;
   logic [7:0] pa_lvl = 8'h00, ext_val = 8'hFF, ext_drv = 8'hFF;
   logic [7:0] pb_pin, dv, mk;
   pabm_periph_t pf_want = 5'h00, periph;
   pabm_pad_t pa_pad, pb_pad, e;
   int err_total = 0, tests_run = 0, cyc = 0, m, p;
   always #50 ref_clk_in = ~ref_clk_in;
   pabm_top uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
      .pa_pin_in(pa_lvl), .pb_pin_in(pb_pin), .periph_in(periph),
      .pa_pad_out(pa_pad), .pb_pad_out(pb_pad), .analog_chan_en_out(),
      .spi_sel_active_out(sel_act), .spi_sck_out(), .spi_mosi_out(),
      .spi_miso_out(), .external_irq_source_2_out(),
      .comparator_positive_input_out(), .comparator_negative_input_out());
   pabm_periph_model peer (.clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .pad_in(pb_pad), .ext_val_in(ext_val), .ext_drv_in(ext_drv),
      .want_in(pf_want), .periph_out(periph), .pin_out(pb_pin));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic chk_pad(input pabm_pad_t g, x, input logic [7:0] k);
      chk({8'h0, g.oe, g.pu, g.o & k}, {8'h0, x.oe, x.pu, x.o & k});
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pen <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      pen <= 1'b1;
      do @(posedge ref_clk_in); while (pready !== 1'b1);
      rd_v = prdata;
      er_v = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 0);
      chk(rd_v, x);
   endtask
   function automatic pabm_pad_t exp_pb(input logic [7:0] d, o,
         input logic global_pullup_disable, en, ms, input pabm_periph_t f);
      pabm_pad_t x;
      logic [7:0] fi;
      fi = !en ? 8'h00 : ms ? 8'h40 : 8'hB0;
      x.oe = d & ~fi;
      x.pu = (~d | fi) & o & {8{~global_pullup_disable}};
      x.o = o;
      if (en && ms) begin
         x.o[7] = f.sck;
         x.o[5] = f.mosi;
      end
      if (f.oc0_en) x.o[3] = f.oc0;
      return x;
   endfunction
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      rdc(`PABM_ADDR_SFC, 32'h0);
      apb(1'b1, `PABM_ADDR_SFC, 32'hFF);
      rdc(`PABM_ADDR_SFC, 32'hEF);
      apb(1'b0, 12'h100, 0);
      chk({31'h0, er_v}, 32'h1);
      chk(rd_v, 32'h0);
      // port a outputs stay still once set, conversions may run
      apb(1'b1, `PABM_ADDR_PA_DIR, 32'h0F);
      apb(1'b1, `PABM_ADDR_PA_OUT, 32'hFF);
      for (int q = 1; q >= 0; q--) begin
         apb(1'b1, `PABM_ADDR_SFC, q ? 32'h04 : 32'h00);
         repeat (2) @(posedge ref_clk_in);
         e = {8'h0F, 8'h0F, q ? 8'h00 : 8'hF0};
         chk_pad(pa_pad, e, 8'h0F);
      end
      rdc(`PABM_ADDR_PA_PIN, 32'h0);
      apb(1'b1, `PABM_ADDR_PB_OUT, 32'hC3);
      for (int i = 0; i < 18; i++) begin
         m = i / 6;
         p = (i / 3) % 2;
         dv = (i % 3 == 0) ? 8'hFF : (i % 3 == 1) ? 8'h00 : 8'h5A;
         pf_want <= p ? 5'h16 : 5'h09;
         apb(1'b1, `PABM_ADDR_SFC, p ? 32'h04 : 32'h00);
         apb(1'b1, `PABM_ADDR_PB_DIR, {24'h0, dv});
         apb(1'b1, `PABM_ADDR_SPI_CTL, m == 0 ? 0 : m == 1 ? 3 : 1);
         repeat (2) @(posedge ref_clk_in);
         e = exp_pb(dv, 8'hC3, p == 1, m != 0, m == 1, pf_want);
         mk = e.oe & (m == 2 ? 8'hBF : 8'hFF);
         chk_pad(pb_pad, e, mk);
      end
      // comparator pins as inputs with pullups off
      apb(1'b1, `PABM_ADDR_PB_DIR, 32'h00);
      apb(1'b0, `PABM_ADDR_IRQ_STAT, 0);
      apb(1'b1, `PABM_ADDR_IRQ_MASK, 32'h03);
      ext_val <= 8'hEB;
      repeat (4) @(posedge ref_clk_in);
      chk({31'h0, sel_act}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdc(`PABM_ADDR_IRQ_STAT, 32'h3);
      repeat (3) @(posedge ref_clk_in);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `PABM_ADDR_IRQ_MASK, 32'h00);
      ext_val <= 8'hEF;
      repeat (4) @(posedge ref_clk_in);
      chk({31'h0, irq}, 32'h0);
      rdc(`PABM_ADDR_IRQ_STAT, 32'h2);
      rdc(`PABM_ADDR_PB_PIN, 32'hEF);
      test_done();
   end
endmodule
